// [hdl/bbd_pkg.sv]
// Shared constants, types and helpers for the branch and bit-operation decoder
package bbd_pkg;

  // Widths
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DADDR_W = 12;
  localparam int unsigned BANK_W = 4;
  localparam int unsigned PC_W_DEF = 21;
  localparam int unsigned PC_W_MIN = 12;

  // Opcode fields
  localparam logic [4:0] OPC_RELATIVE_JUMP = 5'h1a;
  localparam logic [7:0] OPC_JUMP_ON_OVF = 8'he4;
  localparam logic [3:0] OPC_BIT_FORCE_ONE = 4'h8;
  localparam logic [3:0] OPC_BIT_INVERT = 4'h7;
  localparam logic [3:0] OPC_SKIP_ON_CLEAR = 4'hb;
  localparam logic [3:0] OPC_SKIP_ON_ONE = 4'ha;

  // Field positions inside the instruction word
  localparam int unsigned FLD_OP4_LSB = 12;
  localparam int unsigned FLD_OP5_LSB = 11;
  localparam int unsigned FLD_OP8_LSB = 8;
  localparam int unsigned FLD_BIT_LSB = 9;
  localparam int unsigned FLD_ACCESS = 8;
  localparam int unsigned FLD_LONG_OFF_W = 11;
  localparam int unsigned FLD_SHORT_OFF_W = 8;

  // Access bank split and indexed-literal window
  localparam logic [7:0] ACC_LOW_LIMIT = 8'h60;
  localparam logic [7:0] IDX_MAX_ADDR = 8'h5f;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;

  // Phases of one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Idle cycles inserted after a taken branch or skip
  localparam logic [1:0] IDLE_ONE_WORD = 2'h1;
  localparam logic [1:0] IDLE_TWO_WORD = 2'h2;

  typedef enum {
    OP_NONE,
    OP_RELATIVE_JUMP,
    OP_JUMP_ON_OVF,
    OP_BIT_FORCE_ONE,
    OP_BIT_INVERT,
    OP_SKIP_ON_CLEAR,
    OP_SKIP_ON_ONE
  } bbd_op_t;

  function automatic bbd_op_t bbd_decode(input logic [INSTR_W-1:0] instr);
    bbd_op_t op;
    op = OP_NONE;
    if (instr[INSTR_W-1:FLD_OP5_LSB] == OPC_RELATIVE_JUMP) begin
      op = OP_RELATIVE_JUMP;
    end else if (instr[INSTR_W-1:FLD_OP8_LSB] == OPC_JUMP_ON_OVF) begin
      op = OP_JUMP_ON_OVF;
    end else begin
      case (instr[INSTR_W-1:FLD_OP4_LSB])
        OPC_BIT_FORCE_ONE: op = OP_BIT_FORCE_ONE;
        OPC_BIT_INVERT: op = OP_BIT_INVERT;
        OPC_SKIP_ON_CLEAR: op = OP_SKIP_ON_CLEAR;
        OPC_SKIP_ON_ONE: op = OP_SKIP_ON_ONE;
        default: op = OP_NONE;
      endcase
    end
    return op;
  endfunction : bbd_decode

  function automatic logic bbd_is_bit_op(input bbd_op_t op);
    return (op == OP_BIT_FORCE_ONE) || (op == OP_BIT_INVERT) ||
           (op == OP_SKIP_ON_CLEAR) || (op == OP_SKIP_ON_ONE);
  endfunction : bbd_is_bit_op

endpackage : bbd_pkg

// [hdl/bbd_op_if.sv]
// Decoded operand fields passed between the decoder and its helpers
`timescale 1ns/10ps
interface bbd_op_if;
  import bbd_pkg::*;

  bbd_op_t op;
  logic [7:0] faddr;
  logic access;
  logic [2:0] bit_idx;
  logic ext_en;
  logic [BANK_W-1:0] bank_select_register;
  logic [DADDR_W-1:0] index_base;
  logic [DATA_W-1:0] rd_data;
  logic [DADDR_W-1:0] data_addr;
  logic indexed;
  logic [DATA_W-1:0] wr_data;
  logic bit_val;

  modport ctl (
    output op, faddr, access, bit_idx, ext_en, bank_select_register, index_base, rd_data,
    input data_addr, indexed, wr_data, bit_val
  );
  modport agu (
    input faddr, access, ext_en, bank_select_register, index_base,
    output data_addr, indexed
  );
  modport alu (
    input op, bit_idx, rd_data,
    output wr_data, bit_val
  );
endinterface : bbd_op_if

// [hdl/bbd_addr_gen.sv]
// Data address generation for register-addressed bit operations
`timescale 1ns/10ps
module bbd_addr_gen
  import bbd_pkg::*;
(
  bbd_op_if.agu opif
);

  always_comb begin
    opif.indexed = 1'b0;
    if (opif.access) begin
      opif.data_addr = {opif.bank_select_register, opif.faddr};
    end else if (opif.ext_en && (opif.faddr <= IDX_MAX_ADDR)) begin
      opif.indexed = 1'b1;
      opif.data_addr = opif.index_base + {{(DADDR_W-8){1'b0}}, opif.faddr};
    end else if (opif.faddr < ACC_LOW_LIMIT) begin
      opif.data_addr = {{BANK_W{1'b0}}, opif.faddr};
    end else begin
      opif.data_addr = {ACC_HIGH_BANK, opif.faddr};
    end
  end

endmodule : bbd_addr_gen

// [hdl/bbd_bit_alu.sv]
// Single-bit modify and test unit
`timescale 1ns/10ps
module bbd_bit_alu
  import bbd_pkg::*;
(
  bbd_op_if.alu opif
);

  logic [DATA_W-1:0] mask;

  assign mask = {{(DATA_W-1){1'b0}}, 1'b1} << opif.bit_idx;
  assign opif.bit_val = |(opif.rd_data & mask);

  always_comb begin
    case (opif.op)
      OP_BIT_FORCE_ONE: opif.wr_data = opif.rd_data | mask;
      OP_BIT_INVERT: opif.wr_data = opif.rd_data ^ mask;
      default: opif.wr_data = opif.rd_data;
    endcase
  end

endmodule : bbd_bit_alu

// [hdl/bbd_branch_bit_decode.sv]
// Decode and execute of relative jumps, overflow jump, bit modify and bit skip
//
// Overview of operation
// - relative jump, 11-bit offset, target pc+2n
// - relative jump takes two cycles
// - force bit one, flags untouched
// - access bit chooses access or banked
// - extended set, low address uses indexing
// - skip when tested bit is clear
// - skip costs one, two or three cycles
// - skip when tested bit is one
// - invert bit, flags untouched
// - overflow jump, 8-bit offset, flag set
// - conditional jump one or two cycles
// - read-modify-write across four phases
`timescale 1ns/10ps
module bbd_branch_bit_decode
  import bbd_pkg::*;
#(
  parameter int unsigned PC_W = PC_W_DEF
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Instruction fetch
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic next_two_word_i,
  input wire logic [PC_W-1:0] pc_inc_i,
  output logic instr_ack_o,
  output logic discard_o,
  output logic pc_wr_o,
  output logic [PC_W-1:0] pc_target_o,
  // Core state
  input wire logic overflow_flag_i,
  input wire logic ext_set_en_i,
  input wire logic [BANK_W-1:0] bank_select_register_i,
  input wire logic [DADDR_W-1:0] index_base_i,
  // Data register file
  output logic [DADDR_W-1:0] rf_addr_o,
  output logic rf_rd_o,
  input wire logic [DATA_W-1:0] rf_rdata_i,
  output logic rf_wr_o,
  output logic [DATA_W-1:0] rf_wdata_o,
  // Status
  output logic [1:0] phase_o,
  output logic foreign_op_o,
  output logic indexed_mode_o
);

  if (PC_W < PC_W_MIN) begin : g_pc_w_check
    $error("PC_W too narrow for the data address space");
  end

  typedef enum {
    ST_RUN,
    ST_IDLE
  } bbd_state_t;

  function automatic logic [PC_W-1:0] sext_offset(input logic [FLD_LONG_OFF_W-1:0] off);
    return {{(PC_W-FLD_LONG_OFF_W){off[FLD_LONG_OFF_W-1]}}, off};
  endfunction : sext_offset

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer and state

  logic [1:0] phase_reg;
  bbd_state_t state_reg;
  logic [1:0] idle_cnt_reg;
  logic [INSTR_W-1:0] instr_reg;
  bbd_op_t op_reg;
  logic [PC_W-1:0] pc_base_reg;
  logic take_reg;
  logic [1:0] idle_len_reg;
  logic q1_take;
  logic q1_exec;

  bbd_op_if opif ();

  assign q1_take = (phase_reg == PH_Q1) && instr_valid_i;
  // Words that arrive while idling are consumed but never latched
  assign q1_exec = q1_take && (state_reg == ST_RUN);

  // Free-running: phases never stall, idle cycles included
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_reg <= PH_Q1;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // Instruction is taken once per cycle, in Q1
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      instr_reg <= '0;
      pc_base_reg <= '0;
    end else if (q1_exec) begin
      instr_reg <= instr_i;
      pc_base_reg <= pc_inc_i;
    end
  end

  // Discarded or absent words execute as a no-operation
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_reg <= OP_NONE;
    end else if (phase_reg == PH_Q1) begin
      op_reg <= q1_exec ? bbd_decode(instr_i) : OP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand fields to the helpers

  assign opif.op = op_reg;
  // Fields are cut straight from the latched word
  assign opif.faddr = instr_reg[FLD_ACCESS-1:0];
  assign opif.access = instr_reg[FLD_ACCESS];
  assign opif.bit_idx = instr_reg[FLD_OP4_LSB-1:FLD_BIT_LSB];
  assign opif.ext_en = ext_set_en_i;
  assign opif.bank_select_register = bank_select_register_i;
  assign opif.index_base = index_base_i;
  assign opif.rd_data = rf_rdata_i;

  bbd_addr_gen u_addr_gen (
    .opif(opif.agu)
  );

  bbd_bit_alu u_bit_alu (
    .opif(opif.alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file access

  logic bit_op;
  logic bit_write_op;

  assign bit_op = bbd_is_bit_op(op_reg);
  assign bit_write_op = (op_reg == OP_BIT_FORCE_ONE) || (op_reg == OP_BIT_INVERT);

  // address formed at end of Q2
  // Held a whole cycle so the Q4 write hits the word that was read
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rf_addr_o <= '0;
      indexed_mode_o <= 1'b0;
    end else if (phase_reg == PH_Q2) begin
      rf_addr_o <= opif.data_addr;
      indexed_mode_o <= opif.indexed && bit_op;
    end
  end

  // read in Q3, process Q3, write Q4
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rf_rd_o <= 1'b0;
    end else begin
      rf_rd_o <= (phase_reg == PH_Q2) && bit_op;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rf_wr_o <= 1'b0;
    end else begin
      rf_wr_o <= (phase_reg == PH_Q3) && bit_write_op;
    end
  end

  // Data loads only in Q3 and holds through the Q4 write
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rf_wdata_o <= '0;
    end else if (phase_reg == PH_Q3) begin
      rf_wdata_o <= opif.wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Branch and skip decision, made in Q3

  logic skip_op;

  assign skip_op = (op_reg == OP_SKIP_ON_CLEAR) || (op_reg == OP_SKIP_ON_ONE);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      take_reg <= 1'b0;
    end else if (phase_reg == PH_Q3) begin
      case (op_reg)
        OP_RELATIVE_JUMP: take_reg <= 1'b1;
        OP_JUMP_ON_OVF: take_reg <= overflow_flag_i;
        OP_SKIP_ON_CLEAR: take_reg <= !opif.bit_val;
        OP_SKIP_ON_ONE: take_reg <= opif.bit_val;
        default: take_reg <= 1'b0;
      endcase
    end else if (phase_reg == PH_Q1) begin
      take_reg <= 1'b0;
    end
  end

  // two-word victim costs two idles
  // Fetch flags the victim; the decoder cannot see past one word
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_len_reg <= IDLE_ONE_WORD;
    end else if (phase_reg == PH_Q3) begin
      idle_len_reg <= (skip_op && next_two_word_i) ? IDLE_TWO_WORD : IDLE_ONE_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter write in Q4

  logic jump_op;
  logic jump_taken;
  logic [FLD_LONG_OFF_W-1:0] offset_field;

  assign jump_op = (op_reg == OP_RELATIVE_JUMP) || (op_reg == OP_JUMP_ON_OVF);
  // overflow jump only when flag set
  assign jump_taken = (op_reg == OP_RELATIVE_JUMP) ||
    ((op_reg == OP_JUMP_ON_OVF) && overflow_flag_i);

  // short offset widened first
  // Both offsets end up 11 bits so one sign extender serves
  assign offset_field = (op_reg == OP_RELATIVE_JUMP) ? instr_reg[FLD_LONG_OFF_W-1:0] :
    {{(FLD_LONG_OFF_W-FLD_SHORT_OFF_W){instr_reg[FLD_SHORT_OFF_W-1]}},
     instr_reg[FLD_SHORT_OFF_W-1:0]};

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_wr_o <= 1'b0;
    end else begin
      pc_wr_o <= (phase_reg == PH_Q3) && jump_taken;
    end
  end

  // sign extend, wrap modulo space
  // Computed for every word; only meaningful while pc_wr_o is high
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_target_o <= '0;
    end else if (phase_reg == PH_Q3) begin
      pc_target_o <= pc_base_reg + (sext_offset(offset_field) << 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle cycles after a taken jump or skip

  // skip adds one or two idles
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_RUN;
      idle_cnt_reg <= '0;
    end else if (phase_reg == PH_Q4) begin
      case (state_reg)
        ST_RUN: begin
          if (take_reg) begin
            state_reg <= ST_IDLE;
            idle_cnt_reg <= jump_op ? IDLE_ONE_WORD : idle_len_reg;
          end
        end
        ST_IDLE: begin
          if (idle_cnt_reg <= IDLE_ONE_WORD) begin
            state_reg <= ST_RUN;
            idle_cnt_reg <= '0;
          end else begin
            idle_cnt_reg <= idle_cnt_reg - 2'h1;
          end
        end
        default: begin
          state_reg <= ST_RUN;
          idle_cnt_reg <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Prefetched word is consumed but thrown away while idling
  assign instr_ack_o = q1_take;
  assign discard_o = q1_take && (state_reg == ST_IDLE);
  assign phase_o = phase_reg;
  // Lets the core hand other opcodes to its other decoders
  assign foreign_op_o = (op_reg == OP_NONE) && (state_reg == ST_RUN) && (phase_reg != PH_Q1);

endmodule : bbd_branch_bit_decode

// [tb/bbd_props.sv]
// Checker for the branch and bit-operation decoder
`timescale 1ns/10ps
module bbd_props
  import bbd_pkg::*;
#(
  parameter int unsigned PC_W = PC_W_DEF
) (
  // Clock, reset, core inputs
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic next_two_word_i,
  input wire logic [PC_W-1:0] pc_inc_i,
  input wire logic overflow_flag_i,
  input wire logic [BANK_W-1:0] bank_select_register_i,
  input wire logic [DATA_W-1:0] rf_rdata_i,
  // Design outputs
  input wire logic instr_ack_o,
  input wire logic discard_o,
  input wire logic pc_wr_o,
  input wire logic [PC_W-1:0] pc_target_o,
  input wire logic [DADDR_W-1:0] rf_addr_o,
  input wire logic rf_rd_o,
  input wire logic rf_wr_o,
  input wire logic [DATA_W-1:0] rf_wdata_o,
  input wire logic [1:0] phase_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  logic [PC_W-1:0] tgt_reg;
  logic [PC_W-1:0] off_w;
  logic [INSTR_W-1:0] ins_reg;
  logic go;
  logic skip_now;
  assign go = instr_ack_o && !discard_o;
  assign off_w = instr_i[15:11] == OPC_RELATIVE_JUMP ?
    {{(PC_W-11){instr_i[10]}}, instr_i[10:0]} : {{(PC_W-8){instr_i[7]}}, instr_i[7:0]};
  // Skip ops carry the tested polarity inverted in their lowest opcode bit
  assign skip_now = rf_rd_o && ins_reg[15:13] == 3'b101 && rf_rdata_i[ins_reg[11:9]] != ins_reg[12];
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ins_reg <= '0;
      tgt_reg <= '0;
    end else if (go) begin
      ins_reg <= instr_i;
      tgt_reg <= pc_inc_i + (off_w << 1);
    end
  end
  ////////////////////////////////////////
  rel_jump_a: assert property (go && instr_i[15:11] == OPC_RELATIVE_JUMP |->
    ##3 pc_wr_o && pc_target_o == tgt_reg ##1 (discard_o == instr_ack_o) ##4 !discard_o)
    else $error("relative jump target or idle cycle wrong");
  ovf_taken_a: assert property (go && instr_i[15:8] == OPC_JUMP_ON_OVF ##2 overflow_flag_i
    |=> pc_wr_o && pc_target_o == tgt_reg ##1 (discard_o == instr_ack_o))
    else $error("overflow jump not taken as expected");
  ovf_idle_a: assert property (go && instr_i[15:8] == OPC_JUMP_ON_OVF ##2 !overflow_flag_i
    |=> !pc_wr_o ##1 !discard_o) else $error("untaken jump wrote pc or idled");
  force_one_a: assert property (rf_wr_o && ins_reg[15:12] == OPC_BIT_FORCE_ONE |->
    rf_wdata_o == ($past(rf_rdata_i) | (8'h01 << ins_reg[11:9]))) else $error("bit set data wrong");
  invert_bit_a: assert property (rf_wr_o && ins_reg[15:12] == OPC_BIT_INVERT |->
    rf_wdata_o == ($past(rf_rdata_i) ^ (8'h01 << ins_reg[11:9]))) else $error("toggle data wrong");
  rmw_order_a: assert property (rf_wr_o |->
    phase_o == PH_Q4 && $past(rf_rd_o) && $stable(rf_addr_o)) else $error("write not after read");
  skip_taken_a: assert property (skip_now |=> !rf_wr_o ##1 (discard_o == instr_ack_o)
    ##4 (discard_o == (instr_ack_o && $past(next_two_word_i, 6)))) else $error("skip idles wrong");
  skip_none_a: assert property (rf_rd_o && ins_reg[15:13] == 3'b101 && !skip_now
    |=> !rf_wr_o ##1 !discard_o) else $error("skip fired without cause");
  bank_addr_a: assert property (rf_rd_o && ins_reg[FLD_ACCESS] |->
    rf_addr_o == {bank_select_register_i, ins_reg[7:0]}) else $error("banked address wrong");
  cover property (skip_now && next_two_word_i);
  cover property (pc_wr_o);
  cover property (rf_wr_o);
endmodule : bbd_props

bind bbd_branch_bit_decode bbd_props #(.PC_W(PC_W)) i_bbd_props (
  .clock_i, .arst_n_i, .instr_i, .next_two_word_i, .pc_inc_i, .overflow_flag_i,
  .bank_select_register_i, .rf_rdata_i, .instr_ack_o, .discard_o, .pc_wr_o, .pc_target_o,
  .rf_addr_o, .rf_rd_o, .rf_wr_o, .rf_wdata_o, .phase_o
);

// [tb/bbd_rf_model.sv]
// Data register file model behind the decoder
`timescale 1ns/10ps
module bbd_rf_model
  import bbd_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Register file port
  input wire logic [DADDR_W-1:0] rf_addr_i,
  input wire logic rf_rd_i,
  input wire logic rf_wr_i,
  input wire logic [DATA_W-1:0] rf_wdata_i,
  output logic [DATA_W-1:0] rf_rdata_o
);
  logic [DATA_W-1:0] mem [2**DADDR_W];
  logic [DATA_W-1:0] junk_reg = 8'h3c;
  // Off the strobe the bus moves, so stale data never looks valid
  assign rf_rdata_o = rf_rd_i ? mem[rf_addr_i] : junk_reg;
  always @(posedge clock_i) begin
    junk_reg <= junk_reg + 8'h5b;
    if (rf_wr_i) begin
      mem[rf_addr_i] <= rf_wdata_i;
    end
  end
endmodule : bbd_rf_model

// [tb/testbench.sv]
// Self-checking bench for the branch and bit-operation decoder
`timescale 1ns/10ps
module testbench;
  import bbd_pkg::*;
  localparam int unsigned PCW = 16;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = '0;
  logic instr_valid_i = 1'b0;
  logic next_two_word_i = 1'b0;
  logic [PCW-1:0] pc_inc_i = '0;
  logic overflow_flag_i = 1'b0;
  logic ext_set_en_i = 1'b0;
  logic [BANK_W-1:0] bank_select_register_i = 4'h3;
  logic [DADDR_W-1:0] index_base_i = 12'h200;
  logic instr_ack_o, discard_o, pc_wr_o, rf_rd_o, rf_wr_o, indexed_mode_o, foreign_op_o;
  logic [PCW-1:0] pc_target_o;
  logic [DADDR_W-1:0] rf_addr_o;
  logic [DATA_W-1:0] rf_rdata_i, rf_wdata_o;
  logic [1:0] phase_o;
  int mismatches = 0;
  int samples_checked = 0;

  always #10 clock_i = ~clock_i;

  bbd_branch_bit_decode #(.PC_W(PCW)) i_bbd_branch_bit_decode (
    .clock_i, .arst_n_i, .instr_i, .instr_valid_i, .next_two_word_i, .pc_inc_i,
    .instr_ack_o, .discard_o, .pc_wr_o, .pc_target_o, .overflow_flag_i, .ext_set_en_i,
    .bank_select_register_i, .index_base_i, .rf_addr_o, .rf_rd_o, .rf_rdata_i, .rf_wr_o,
    .rf_wdata_o, .phase_o, .foreign_op_o, .indexed_mode_o
  );
  bbd_rf_model i_bbd_rf_model (
    .clock_i, .rf_addr_i(rf_addr_o), .rf_rd_i(rf_rd_o), .rf_wr_i(rf_wr_o),
    .rf_wdata_i(rf_wdata_o), .rf_rdata_o(rf_rdata_i)
  );
  ////////////////////////////////////////
  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : chk

  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask : tick

  // Present a word in the next Q1 clock; returns one clock later
  task automatic run(input logic [INSTR_W-1:0] w);
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (phase_o !== PH_Q1 && n < 8);
    if (phase_o !== PH_Q1) begin
      $display("ERROR phase expected %h seen %h", PH_Q1, phase_o);
      mismatches++;
      close_out();
    end else begin
      instr_i = w;
      tick();
      instr_i = '0;
    end
  endtask : run

  task automatic t_br(input logic [INSTR_W-1:0] w, input logic [PCW-1:0] pc, input logic ov);
    logic [PCW-1:0] off;
    logic [PCW-1:0] tgt;
    logic taken;
    off = w[15:11] == OPC_RELATIVE_JUMP ? {{(PCW-11){w[10]}}, w[10:0]} : {{(PCW-8){w[7]}}, w[7:0]};
    tgt = pc + (off << 1);
    taken = w[15:11] == OPC_RELATIVE_JUMP || ov;
    pc_inc_i = pc;
    overflow_flag_i = ov;
    run(w);
    tick();
    tick();
    chk("pc_wr", taken, pc_wr_o);
    if (taken) begin
      chk("pc_target", tgt, pc_target_o);
    end
    tick();
    chk("ack", 1'b1, instr_ack_o);
    chk("discard", taken, discard_o);
  endtask : t_br

  task automatic t_bit(input logic [INSTR_W-1:0] w, input logic ext, input logic two,
      input logic [11:0] a, input logic [7:0] pre, input logic [7:0] res);
    logic sk_op;
    logic skip;
    sk_op = w[15:13] == 3'b101;
    skip = sk_op && pre[w[11:9]] != w[12];
    ext_set_en_i = ext;
    next_two_word_i = two;
    i_bbd_rf_model.mem[a] = pre;
    run(w);
    tick();
    chk("rf_addr", a, rf_addr_o);
    chk("indexed", !w[8] && ext && w[7:0] <= IDX_MAX_ADDR, indexed_mode_o);
    chk("rf_rd", 1'b1, rf_rd_o);
    chk("foreign", 1'b0, foreign_op_o);
    tick();
    chk("rf_wr", !sk_op, rf_wr_o);
    tick();
    chk("data", res, i_bbd_rf_model.mem[a]);
    chk("discard", skip, discard_o);
    repeat (4) tick();
    chk("discard_second", skip && two, discard_o);
  endtask : t_bit

  // Words outside this decoder's set must run as a no-operation
  task automatic t_foreign(input logic [INSTR_W-1:0] w);
    run(w);
    chk("foreign", 1'b1, foreign_op_o);
    tick();
    chk("rf_rd", 1'b0, rf_rd_o);
    tick();
    chk("pc_wr", 1'b0, pc_wr_o);
    chk("rf_wr", 1'b0, rf_wr_o);
    tick();
    chk("discard", 1'b0, discard_o);
  endtask : t_foreign

  initial begin
    repeat (16) @(posedge clock_i);
    #1;
    arst_n_i = 1'b1;
    instr_valid_i = 1'b1;
    t_br(16'hd3ff, 16'h0100, 1'b0);
    t_br(16'hd400, 16'h0002, 1'b0);
    t_br(16'he480, 16'h0040, 1'b1);
    t_br(16'he47f, 16'h0040, 1'b0);
    t_bit(16'h8f45, 1'b0, 1'b0, 12'h345, 8'h0a, 8'h8a);
    t_bit(16'h7882, 1'b0, 1'b0, 12'hf82, 8'h75, 8'h65);
    t_bit(16'h8010, 1'b0, 1'b0, 12'h010, 8'hfe, 8'hff);
    t_bit(16'h705f, 1'b1, 1'b0, 12'h25f, 8'h01, 8'h00);
    t_bit(16'h8460, 1'b1, 1'b0, 12'hf60, 8'h00, 8'h04);
    t_bit(16'hb345, 1'b0, 1'b0, 12'h345, 8'h8a, 8'h8a);
    t_bit(16'hb145, 1'b0, 1'b0, 12'h345, 8'h8a, 8'h8a);
    t_bit(16'haf45, 1'b0, 1'b1, 12'h345, 8'h8a, 8'h8a);
    t_bit(16'ha145, 1'b0, 1'b1, 12'h345, 8'h8a, 8'h8a);
    t_foreign(16'he545);
    t_foreign(16'h9345);
    close_out();
  end
endmodule : testbench
